// >>> csel_loader.sv
// start-up loader of the bus node number and bit rate
// assumes switches arrive from pins; stored and file settings come from
// logic on clk_sys and hold steady while the loader runs
// How it works
// - default node one at 1000 kBd
// - high switch upper digit, low switch lower
// - codes 0x01 to 0x7F: fixed rate, node equals code; code 0x00: fixed rate, object node
// - codes above 0x80: stored rate, node code minus 128; code 0x80: stored rate, object node
// - stored rate codes map to listed rates
// - load default, stored, file, then switches
// - changes apply only after reset or comm reset
// - statusword upload request while config_done gets two data byte answer, zero padded
`timescale 1ns/1ps
module csel_loader
  import csel_pkg::*;
#(
  parameter int SETTLE_CYCLES = CSEL_SETTLE_CYC  // wait for synchronised switches
)(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [3:0]  switch_low_digit,     // first rotary switch, pin
  input  wire logic [3:0]  switch_high_digit,    // second rotary switch, pin
  input  wire logic        stored_present,       // persistent copy exists
  input  wire logic [6:0]  stored_node_number,
  input  wire logic [7:0]  stored_bit_rate_code,
  input  wire logic        cfg_node_present,     // file sets node number
  input  wire logic [6:0]  cfg_node_number,
  input  wire logic        cfg_rate_present,     // file sets bit rate code
  input  wire logic [7:0]  cfg_bit_rate_code,
  input  wire logic        comm_reset,           // reset-communication pulse
  input  wire logic        sdo_req_valid,
  input  wire logic [63:0] sdo_req_data,
  input  wire logic [15:0] statusword,
  output logic      [6:0]  node_id,
  output logic      [7:0]  bit_rate_code,
  output logic      [9:0]  bit_rate_kbd,
  output logic             config_done,
  output logic             sdo_resp_valid,
  output logic      [63:0] sdo_resp_data
);

  // the settle counter is 8 bits and must outlast the synchroniser
  if (SETTLE_CYCLES < 2 || SETTLE_CYCLES > 255) begin : g_chk
    $error("csel_loader: SETTLE_CYCLES out of range");
  end

  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);

  // switch synchronisers; the _m stage feeds nothing but the _s stage
  logic [7:0]  sw_m_r;         // first stage
  logic [7:0]  sw_s_r;         // second stage, safe to read
  logic [7:0]  sw_m_nxt;
  logic [7:0]  sw_s_nxt;

  // loader state
  csel_state_t state_r;        // current phase
  csel_state_t state_nxt;
  logic [7:0]  settle_r;       // cycles spent settling
  logic [7:0]  settle_nxt;
  logic [6:0]  node_r;         // applied node number
  logic [6:0]  node_nxt;
  logic [7:0]  rate_r;         // applied rate code
  logic [7:0]  rate_nxt;
  logic [9:0]  kbd_r;          // applied rate in kBd, registered
  logic [9:0]  kbd_nxt;
  logic        done_r;         // settings applied
  logic        done_nxt;

  // interface check answer
  logic        resp_vld_r;
  logic        resp_vld_nxt;
  logic [63:0] resp_r;
  logic [63:0] resp_nxt;

  // object values after the first three load steps
  logic [6:0]  obj_node;
  logic [7:0]  obj_rate;
  logic [9:0]  stored_kbd;     // unused width, only validity matters
  logic        stored_ok;
  logic [9:0]  cfg_kbd;
  logic        cfg_ok;
  logic        out_ok;

  csel_rate_decode u_dec_stored (
    .rate_code (stored_bit_rate_code),
    .rate_kbd  (stored_kbd),
    .rate_ok   (stored_ok)
  );

  csel_rate_decode u_dec_cfg (
    .rate_code (cfg_bit_rate_code),
    .rate_kbd  (cfg_kbd),
    .rate_ok   (cfg_ok)
  );

  // rate reported outward, decoded ahead so the output comes from a flop
  csel_rate_decode u_dec_out (
    .rate_code (rate_nxt),
    .rate_kbd  (kbd_nxt),
    .rate_ok   (out_ok)
  );

  // object layering; a bad rate code cannot override a good one
  always_comb begin
    obj_node = CSEL_DEF_NODE;
    obj_rate = CSEL_DEF_RATE_CODE;
    if (stored_present) begin
      obj_node = stored_node_number;
      if (stored_ok) begin
        obj_rate = stored_bit_rate_code;
      end
    end
    if (cfg_node_present) begin
      obj_node = cfg_node_number;
    end
    if (cfg_rate_present && cfg_ok) begin
      obj_rate = cfg_bit_rate_code;
    end
  end

  // synchroniser next values
  always_comb begin
    sw_m_nxt = {switch_high_digit, switch_low_digit};
    sw_s_nxt = sw_m_r;
  end

  always_ff @(posedge clk_sys) begin
    sw_m_r <= sw_m_nxt;
    sw_s_r <= sw_s_nxt;
  end

  // phase sequencing and the final switch step of the load
  always_comb begin
    state_nxt  = state_r;
    settle_nxt = settle_r;
    node_nxt   = node_r;
    rate_nxt   = rate_r;
    done_nxt   = done_r;
    unique case (state_r)
      CSEL_ST_SETTLE: begin
        // let the switch synchroniser fill before sampling
        settle_nxt = settle_r + 8'h01;
        if (settle_r == SETTLE_LAST) begin
          state_nxt = CSEL_ST_LOAD;
        end
      end
      CSEL_ST_LOAD: begin
        // switches take over last, one sample only
        if (sw_s_r == CSEL_CODE_ZERO) begin
          node_nxt = obj_node;
          rate_nxt = CSEL_RC_1000;
        end else if (sw_s_r < CSEL_CODE_SPLIT) begin
          node_nxt = sw_s_r[6:0];
          rate_nxt = CSEL_RC_1000;
        end else if (sw_s_r == CSEL_CODE_SPLIT) begin
          node_nxt = obj_node;
          rate_nxt = obj_rate;
        end else begin
          node_nxt = 7'(sw_s_r - CSEL_NODE_OFFSET);
          rate_nxt = obj_rate;
        end
        done_nxt  = 1'b1;
        state_nxt = CSEL_ST_RUN;
      end
      CSEL_ST_RUN: begin
        // held until a comm reset; stored edits wait for it
        if (comm_reset) begin
          done_nxt   = 1'b0;
          settle_nxt = 8'h00;
          state_nxt  = CSEL_ST_SETTLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r  <= CSEL_ST_SETTLE;
      settle_r <= 8'h00;
      node_r   <= CSEL_DEF_NODE;
      rate_r   <= CSEL_DEF_RATE_CODE;
      kbd_r    <= CSEL_KBD_1000;
      done_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
      node_r   <= node_nxt;
      rate_r   <= rate_nxt;
      kbd_r    <= kbd_nxt;
      done_r   <= done_nxt;
    end
  end

  // statusword upload answer, low byte first, padded with zeros
  always_comb begin
    resp_vld_nxt = 1'b0;
    resp_nxt     = resp_r;
    if (sdo_req_valid && done_r && sdo_req_data == CSEL_SW_UPLOAD_REQ) begin
      resp_vld_nxt = 1'b1;
      resp_nxt     = {CSEL_UPLOAD_RESP, CSEL_SW_INDEX[7:0], CSEL_SW_INDEX[15:8],
                      CSEL_SW_SUBINDEX, statusword[7:0], statusword[15:8], 16'h0000};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp_vld_r <= 1'b0;
      resp_r     <= 64'h0000_0000_0000_0000;
    end else begin
      resp_vld_r <= resp_vld_nxt;
      resp_r     <= resp_nxt;
    end
  end

  assign node_id        = node_r;
  assign bit_rate_code  = rate_r;
  assign bit_rate_kbd   = kbd_r;
  assign config_done    = done_r;
  assign sdo_resp_valid = resp_vld_r;
  assign sdo_resp_data  = resp_r;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // reset itself is the trigger here, so the default disable is switched off
  property p_default_reset;
    disable iff (1'b0)
    rst ##1 !rst |-> node_id == CSEL_DEF_NODE && bit_rate_code == CSEL_RC_1000 &&
      bit_rate_kbd == CSEL_KBD_1000 && !config_done;
  endproperty
  a_default_reset: assert property (p_default_reset) else $error("bad default");

  property p_code_form;
    state_r == CSEL_ST_LOAD |-> sw_s_r == $past({switch_high_digit, switch_low_digit}, 2);
  endproperty
  a_code_form: assert property (p_code_form) else $error("switch code skew");

  property p_low_codes;
    state_r == CSEL_ST_LOAD && sw_s_r != 8'h00 && sw_s_r < 8'h80 |=>
      node_id == $past(sw_s_r[6:0]) && bit_rate_code == 8'h88 && bit_rate_kbd == 10'h3E8;
  endproperty
  a_low_codes: assert property (p_low_codes) else $error("low code wrong");

  property p_zero_code;
    state_r == CSEL_ST_LOAD && sw_s_r == 8'h00 |=>
      node_id == $past(obj_node) && bit_rate_code == 8'h88;
  endproperty
  a_zero_code: assert property (p_zero_code) else $error("code zero wrong");

  property p_high_codes;
    state_r == CSEL_ST_LOAD && sw_s_r >= 8'h80 |=>
      bit_rate_code == $past(obj_rate) &&
      node_id == ($past(sw_s_r) == 8'h80 ? $past(obj_node) : $past(sw_s_r[6:0]));
  endproperty
  a_high_codes: assert property (p_high_codes) else $error("high code wrong");

  property p_rate_table;
    bit_rate_code == 8'h84 |-> bit_rate_kbd == 10'h07D && out_ok;
  endproperty
  a_rate_table: assert property (p_rate_table) else $error("rate table wrong");

  property p_file_wins;
    state_r == CSEL_ST_LOAD && sw_s_r == 8'h80 && cfg_node_present |=>
      node_id == $past(cfg_node_number);
  endproperty
  a_file_wins: assert property (p_file_wins) else $error("load order wrong");

  property p_hold_run;
    state_r == CSEL_ST_RUN && !comm_reset |=> $stable(node_id) && $stable(bit_rate_code);
  endproperty
  a_hold_run: assert property (p_hold_run) else $error("changed without reset");

  property p_status_answer;
    sdo_req_valid && config_done && sdo_req_data == CSEL_SW_UPLOAD_REQ |=>
      sdo_resp_valid && sdo_resp_data[63:32] == 32'h4B41_6000 &&
      sdo_resp_data[15:0] == 16'h0000 &&
      sdo_resp_data[31:16] == {$past(statusword[7:0]), $past(statusword[15:8])};
  endproperty
  a_status_answer: assert property (p_status_answer) else $error("bad answer");

  property p_sample_once;
    config_done && !comm_reset && sw_s_r != $past(sw_s_r) |=> $stable(node_id);
  endproperty
  a_sample_once: assert property (p_sample_once) else $error("switch resampled");

  c_comm_reset: cover property (state_r == CSEL_ST_RUN && comm_reset ##[1:300] config_done);
  c_upper_code: cover property (state_r == CSEL_ST_LOAD && sw_s_r > 8'h80);
  c_answer:     cover property (sdo_resp_valid);

endmodule : csel_loader

// >>> csel_loader_test.sv
// bench for csel_loader: factory values, layering, switch codes, check frames
// assumes csel_master_model plays the master; one 250 MHz clock domain
`timescale 1ns/1ps
module csel_loader_test;
  import csel_pkg::*;
  localparam int S = 2;                       // short settle keeps runs brief
  logic        clk_sys, rst, comm_reset, sdo_req_valid, sdo_resp_valid, config_done;
  logic [3:0]  switch_low_digit, switch_high_digit;
  logic        stored_present, cfg_node_present, cfg_rate_present;
  logic [6:0]  stored_node_number, cfg_node_number, node_id;
  logic [7:0]  stored_bit_rate_code, cfg_bit_rate_code, bit_rate_code;
  logic [9:0]  bit_rate_kbd;
  logic [15:0] statusword;
  logic [63:0] sdo_req_data, sdo_resp_data;
  logic [63:0] exp_q [$];                     // expected answers, oldest first
  logic [16:0] seed = 17'h1_2215;             // lfsr start value
  logic [14:0] e;                             // expected {node, rate code}
  logic [7:0]  rates [9] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h88, 8'h87, 8'h00};
  logic [7:0]  codes [6] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'h81, 8'hFF};
  int          n_errors, checks_done, cyc;

  csel_loader #(.SETTLE_CYCLES(S)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .switch_low_digit(switch_low_digit), .switch_high_digit(switch_high_digit),
    .stored_present(stored_present), .stored_node_number(stored_node_number),
    .stored_bit_rate_code(stored_bit_rate_code), .cfg_node_present(cfg_node_present),
    .cfg_node_number(cfg_node_number), .cfg_rate_present(cfg_rate_present),
    .cfg_bit_rate_code(cfg_bit_rate_code), .comm_reset(comm_reset),
    .sdo_req_valid(sdo_req_valid), .sdo_req_data(sdo_req_data), .statusword(statusword),
    .node_id(node_id), .bit_rate_code(bit_rate_code), .bit_rate_kbd(bit_rate_kbd),
    .config_done(config_done), .sdo_resp_valid(sdo_resp_valid),
    .sdo_resp_data(sdo_resp_data));
  csel_master_model m_u (.clk_sys(clk_sys), .comm_reset(comm_reset),
    .sdo_req_valid(sdo_req_valid), .sdo_req_data(sdo_req_data));

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  // valid stored codes only; others leave the earlier layer in place
  function automatic logic rc_ok(input logic [7:0] c);
    return c inside {[8'h81:8'h86], 8'h88};
  endfunction : rc_ok
  function automatic logic [9:0] kbd(input logic [7:0] c);
    case (c)
      8'h81:   return 10'h00A;
      8'h82:   return 10'h014;
      8'h83:   return 10'h032;
      8'h84:   return 10'h07D;
      8'h85:   return 10'h0FA;
      8'h86:   return 10'h1F4;
      default: return 10'h3E8;
    endcase
  endfunction : kbd
  // default, stored, file, then switch code, each overriding the last
  function automatic logic [14:0] expect_cfg(input logic [7:0] code);
    logic [6:0] n;
    logic [7:0] r;
    n = 7'h01;
    r = 8'h88;
    if (stored_present) n = stored_node_number;
    if (stored_present && rc_ok(stored_bit_rate_code)) r = stored_bit_rate_code;
    if (cfg_node_present) n = cfg_node_number;
    if (cfg_rate_present && rc_ok(cfg_bit_rate_code)) r = cfg_bit_rate_code;
    if (code < 8'h80) r = 8'h88;
    if (code != 8'h00 && code != 8'h80) n = code[6:0];  // low seven bits: the code itself, or code minus 128 above 0x80
    return {n, r};
  endfunction : expect_cfg

  task automatic check(input string nm, input logic [63:0] ex, input logic [63:0] got);
    checks_done++;
    if (got !== ex) begin
      $display("Error %s expected %h seen %h", nm, ex, got);
      n_errors++;
    end
  endtask : check
  task automatic step();
    repeat (17) seed = lfsr(seed);
  endtask : step
  // bounded wait for the applied settings
  task automatic wait_done();
    int n;
    n = 0;
    while (config_done !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : wait_done
  task automatic check_cfg();
    check("node_id", 64'(e[14:8]), 64'(node_id));
    check("bit_rate_code", 64'(e[7:0]), 64'(bit_rate_code));
    check("bit_rate_kbd", 64'(kbd(e[7:0])), 64'(bit_rate_kbd));
  endtask : check_cfg
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      $display("Error timeout expected done seen running");
      complete_run();
    end
  end
  // answer watcher: each pulse takes the oldest note; mid-cycle, once settled
  always @(negedge clk_sys) begin
    if (sdo_resp_valid === 1'b1 && exp_q.size() == 0) begin
      n_errors++;
      $display("Error sdo_resp_valid expected 0 seen 1");
    end else if (sdo_resp_valid === 1'b1) begin
      check("sdo_resp_data", exp_q.pop_front(), sdo_resp_data);
    end
  end

  initial begin
    rst = 1'b1;
    {switch_high_digit, switch_low_digit} = 8'h01;
    {stored_present, cfg_node_present, cfg_rate_present} = 3'h0;
    {stored_node_number, cfg_node_number} = 14'h0000;
    {stored_bit_rate_code, cfg_bit_rate_code} = 16'h0000;
    statusword = 16'h0000;
    repeat (20) @(posedge clk_sys);
    #1;
    check("reset node_id", 64'h01, 64'(node_id));
    check("reset kbd", 64'h3E8, 64'(bit_rate_kbd));
    check("reset config_done", 64'h0, 64'(config_done));
    rst = 1'b0;
    e = expect_cfg(8'h01);
    wait_done();
    check_cfg();
    $display("test start-up done");
    for (int i = 0; i < 24; i++) begin
      step();
      // stored copy stands for what the master kept with the signature
      {stored_present, cfg_node_present, cfg_rate_present} = seed[2:0];
      stored_node_number = seed[9:3];
      stored_bit_rate_code = rates[seed[13:10] % 9];
      step();
      cfg_node_number = seed[6:0];
      cfg_bit_rate_code = rates[seed[10:7] % 9];
      {switch_high_digit, switch_low_digit} = (i < 6) ? codes[i] : seed[16:9];
      e = expect_cfg({switch_high_digit, switch_low_digit});
      m_u.reset_comm();
      @(posedge clk_sys);
      #1;
      check("config_done reload", 64'h0, 64'(config_done));
      wait_done();
      check_cfg();
      // pins and stored copy move in run; applied values stay
      switch_low_digit = ~switch_low_digit;
      stored_node_number = ~stored_node_number;
      repeat (6) @(posedge clk_sys);
      #1;
      check_cfg();
    end
    $display("test layering done");
    for (int k = 0; k < 4; k++) begin
      step();
      statusword = seed[15:0];
      exp_q.push_back({32'h4B41_6000, statusword[7:0], statusword[15:8], 16'h0000});
      m_u.send(64'h4041_6000_0000_0000, k == 3);
    end
    @(posedge clk_sys);
    #1;
    m_u.send(64'h4041_6001_0000_0000, 1'b0);
    m_u.send(64'h4041_6000_0000_0001, 1'b1);
    m_u.reset_comm();
    @(posedge clk_sys);
    #1;
    m_u.send(64'h4041_6000_0000_0000, 1'b1);
    wait_done();
    repeat (4) @(posedge clk_sys);
    #1;
    check("answers left", 64'h0, 64'(exp_q.size()));
    $display("test check frame done");
    complete_run();
  end
endmodule : csel_loader_test

// >>> csel_master_model.sv
// bus master model: sends the reset-communication command and check frames
// assumes the bench calls its tasks just after a rising edge of clk_sys
`timescale 1ns/1ps
module csel_master_model
  import csel_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             comm_reset,
  output logic             sdo_req_valid,
  output logic      [63:0] sdo_req_data
);
  import csel_pkg::*;

  // idle at time zero, nothing requested
  initial begin
    comm_reset    = 1'b0;
    sdo_req_valid = 1'b0;
    sdo_req_data  = 64'h0000_0000_0000_0000;
  end

  // one-cycle reset-communication command, held across one edge
  task automatic reset_comm();
    comm_reset = 1'b1;
    @(posedge clk_sys);
    #1;
    comm_reset = 1'b0;
  endtask : reset_comm

  // one frame held across its sampling edge; last releases the line
  task automatic send(input logic [63:0] d, input logic last);
    sdo_req_valid = 1'b1;
    sdo_req_data  = d;
    @(posedge clk_sys);
    #1;
    if (last) begin
      sdo_req_valid = 1'b0;
      sdo_req_data  = ~d;  // released line must not keep showing the frame
    end
  endtask : send
endmodule : csel_master_model

// >>> csel_pkg.sv
// constants shared by the node number and bit rate loader
// assumes one 250 MHz clock and a synchronous active-high reset
package csel_pkg;

  // factory setting
  localparam logic [6:0]  CSEL_DEF_NODE      = 7'h01;    // node number out of the box
  localparam logic [7:0]  CSEL_DEF_RATE_CODE = 8'h88;    // 1000 kBd in stored-code form

  // selection code split
  localparam logic [7:0]  CSEL_CODE_ZERO     = 8'h00;    // node from object, fixed rate
  localparam logic [7:0]  CSEL_CODE_SPLIT    = 8'h80;    // first code with stored rate
  localparam logic [7:0]  CSEL_NODE_OFFSET   = 8'h80;    // 128 taken off upper codes

  // stored bit rate codes and their rates in kBd
  localparam logic [7:0]  CSEL_RC_10         = 8'h81;
  localparam logic [7:0]  CSEL_RC_20         = 8'h82;
  localparam logic [7:0]  CSEL_RC_50         = 8'h83;
  localparam logic [7:0]  CSEL_RC_125        = 8'h84;
  localparam logic [7:0]  CSEL_RC_250        = 8'h85;
  localparam logic [7:0]  CSEL_RC_500        = 8'h86;
  localparam logic [7:0]  CSEL_RC_1000       = 8'h88;
  localparam logic [9:0]  CSEL_KBD_10        = 10'h00A;
  localparam logic [9:0]  CSEL_KBD_20        = 10'h014;
  localparam logic [9:0]  CSEL_KBD_50        = 10'h032;
  localparam logic [9:0]  CSEL_KBD_125       = 10'h07D;
  localparam logic [9:0]  CSEL_KBD_250       = 10'h0FA;
  localparam logic [9:0]  CSEL_KBD_500       = 10'h1F4;
  localparam logic [9:0]  CSEL_KBD_1000      = 10'h3E8;

  // interface check frames, first byte in bits 63:56
  localparam logic [63:0] CSEL_SW_UPLOAD_REQ = 64'h4041_6000_0000_0000;
  localparam logic [7:0]  CSEL_UPLOAD_RESP   = 8'h4B;    // two data bytes answer
  localparam logic [15:0] CSEL_SW_INDEX      = 16'h6041; // statusword object
  localparam logic [7:0]  CSEL_SW_SUBINDEX   = 8'h00;

  // timing
  localparam int          CSEL_SETTLE_CYC    = 4;        // switch settle wait, cycles

  // loader states, one-hot
  typedef enum logic [2:0] {
    CSEL_ST_SETTLE = 3'b001,
    CSEL_ST_LOAD   = 3'b010,
    CSEL_ST_RUN    = 3'b100
  } csel_state_t;

endpackage : csel_pkg

// >>> csel_rate_decode.sv
// decoder from stored bit rate code to rate in kBd
// assumes a combinational caller; unknown codes report not valid
`timescale 1ns/1ps
module csel_rate_decode
  import csel_pkg::*;
(
  input  wire logic [7:0] rate_code,
  output logic      [9:0] rate_kbd,
  output logic            rate_ok
);

  // table lookup; 0x87 is a hole in the table and stays invalid
  always_comb begin
    rate_ok  = 1'b1;
    rate_kbd = 10'h000;
    unique case (rate_code)
      CSEL_RC_10:   rate_kbd = CSEL_KBD_10;
      CSEL_RC_20:   rate_kbd = CSEL_KBD_20;
      CSEL_RC_50:   rate_kbd = CSEL_KBD_50;
      CSEL_RC_125:  rate_kbd = CSEL_KBD_125;
      CSEL_RC_250:  rate_kbd = CSEL_KBD_250;
      CSEL_RC_500:  rate_kbd = CSEL_KBD_500;
      CSEL_RC_1000: rate_kbd = CSEL_KBD_1000;
      default:      rate_ok  = 1'b0;          // any other code
    endcase
  end

endmodule : csel_rate_decode
